// File: logic/cab_supervisor.sv
// Cab car supervisor: alertness watchdog, overspeed trip, record triggers.
// Assumes all inputs synchronous to mclk; speed/pressures in tenths.
//
// Contract
// - Record every channel once per four minutes
// - Record when speed moves 1 mph
// - Record when pipe or cylinder moves 2 psi
// - Record on any digital input edge
// - Horn valve follows horn sequencer request
// - Aux lights on manual button or horn
// - Valves energised when healthy, off at reset
// - Overspeed limit chosen by stop system, adjustable
// - Zero speed output below adjustable threshold
// - Overspeed drops the overspeed valve
// - Indicate stop system switched in or out
// - Operator actions restart the alertness timer
// - Timeout raises audible and visual alarms
// - Watchdog enabled only in lead, cut in
// - Visual flashes 5 s, audible 20 s
// - No action in window drops penalty valve
// - Timeouts 240, 162, 135 s at low speed
// - Timeouts shorten to 60 s at speed
// - Time reference reception is its own record
`timescale 1ns/1ps
`include "cab_supervisor_defs.svh"

module cab_supervisor
	import cab_supervisor_pkg::*;
#(
	parameter int SEC_CYCLES = `SEC_CYCLES,
	parameter int DIG_W = 36
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Measurements
	input wire logic [15:0] speed,
	input wire logic [15:0] brake_pipe,
	input wire logic [15:0] brake_cyl,
	input wire logic [15:0] indep_brake,
	// Operator controls and car state
	input wire logic lead_position,
	input wire logic auto_brake_cut_in,
	input wire logic suppression_position,
	input wire logic [3:0] throttle,
	input wire logic reverser_fwd,
	input wire logic reverser_rev,
	input wire logic headlight,
	input wire logic horn_button,
	input wire logic dyn_brake_setup,
	input wire logic bell,
	input wire logic console_reset,
	input wire logic stop_ack,
	input wire logic radio_handle,
	input wire logic manual_sand,
	input wire logic stop_select,
	// Horn and lights
	input wire logic horn_sequencer_request,
	input wire logic horn_signal,
	input wire logic manual_light_request,
	// Recorder sources
	input wire logic [DIG_W-1:0] digital_inputs,
	input wire logic time_ref_pulse,
	// Valves, alarms, indicators
	output logic alert_valve,
	output logic overspeed_valve,
	output logic horn_valve,
	output logic aux_lights,
	output logic alert_audible,
	output logic alert_visual,
	output logic zero_speed,
	output logic stop_system_switched_in,
	output logic stop_system_switched_out,
	// Event recorder sample port
	output logic record_strobe,
	output logic [`CAUSE_W-1:0] record_cause,
	output logic [15:0] record_speed,
	output logic [15:0] record_brake_pipe,
	output logic [15:0] record_brake_cyl,
	output logic [DIG_W-1:0] record_digital
);
	import cab_supervisor_pkg::*;

	localparam int CW = $clog2(SEC_CYCLES);

	// A one-cycle prescaler cannot form a flashing phase
	if (SEC_CYCLES < 2 || DIG_W < 1) begin : g_bad_params
		$error("cab_supervisor: SEC_CYCLES must be >= 2 and DIG_W >= 1");
	end

	// Absolute difference of two tenths values
	function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
		absdiff = (a > b) ? (a - b) : (b - a);
	endfunction

	// Timeout for a speed: highest breakpoint not above the speed
	function automatic logic [7:0] timeout_for(input logic [15:0] s);
		if (s >= `BP_60MPH) timeout_for = `TO_60MPH;
		else if (s >= `BP_50MPH) timeout_for = `TO_50MPH;
		else if (s >= `BP_40MPH) timeout_for = `TO_40MPH;
		else if (s >= `BP_30MPH) timeout_for = `TO_30MPH;
		else if (s >= `BP_20MPH) timeout_for = `TO_20MPH;
		else if (s >= `BP_10MPH) timeout_for = `TO_10MPH;
		else if (s >= `BP_2MPH) timeout_for = `TO_2MPH;
		else timeout_for = `TO_LOW;
	endfunction

	// Second prescaler
	logic [CW-1:0] sec_cnt, next_sec_cnt;
	logic sec_tick;
	logic flash_on; // First half of each second lights the lamp

	always_comb begin
		sec_tick = (sec_cnt == CW'(SEC_CYCLES - 1));
		next_sec_cnt = sec_tick ? '0 : sec_cnt + 1'b1;
		flash_on = (sec_cnt < CW'(SEC_CYCLES / 2));
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) sec_cnt <= '0;
		else sec_cnt <= next_sec_cnt;
	end

	// Adjustable thresholds and register port
	logic [15:0] limit_out, limit_in, zero_thr;
	logic [15:0] next_limit_out, next_limit_in, next_zero_thr;
	logic [31:0] rec_count, next_rec_count; // Records issued since reset
	logic [31:0] next_rdata;
	logic [15:0] selected_limit;
	alert_state_type state, next_state;
	logic overspeed_trip, next_overspeed_trip;
	logic watch_enable;

	always_comb begin
		next_limit_out = limit_out;
		next_limit_in = limit_in;
		next_zero_thr = zero_thr;
		// Both limits and the zero threshold stay adjustable
		if (reg_write) begin
			unique case (reg_addr)
				`REG_LIMIT_OUT: next_limit_out = reg_wdata[15:0];
				`REG_LIMIT_IN: next_limit_in = reg_wdata[15:0];
				`REG_ZERO_THR: next_zero_thr = reg_wdata[15:0];
				default: ; // Read-only or unmapped: write ignored
			endcase
		end
		next_rdata = '0;
		if (reg_read) begin
			unique case (reg_addr)
				`REG_LIMIT_OUT: next_rdata = {16'h0000, limit_out};
				`REG_LIMIT_IN: next_rdata = {16'h0000, limit_in};
				`REG_ZERO_THR: next_rdata = {16'h0000, zero_thr};
				`REG_STATUS: next_rdata = {24'h000000, overspeed_trip, watch_enable,
					stop_select, 1'b0, state};
				`REG_REC_COUNT: next_rdata = rec_count;
				default: next_rdata = '0; // Unmapped reads as zero
			endcase
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			limit_out <= `LIMIT_OUT_RESET;
			limit_in <= `LIMIT_IN_RESET;
			zero_thr <= `ZERO_THR_RESET;
			reg_rdata <= '0;
		end else begin
			limit_out <= next_limit_out;
			limit_in <= next_limit_in;
			zero_thr <= next_zero_thr;
			reg_rdata <= next_rdata;
		end
	end

	// Operator action detection
	logic [7:0] level_now, level_prev; // Throttle, reverser, headlight: any edge counts
	logic [7:0] button_now, button_prev; // Pushbuttons and handles: press counts
	logic [15:0] auto_ref, next_auto_ref; // Brake pipe at the last accepted action
	logic action;

	always_comb begin
		level_now = {throttle, reverser_fwd, reverser_rev, headlight, 1'b0};
		button_now = {horn_button, dyn_brake_setup, bell, console_reset, stop_ack,
			radio_handle, manual_sand, indep_brake > `INDEP_APPLIED};
		// Any qualifying action restarts the timer
		action = (level_now != level_prev) || ((button_now & ~button_prev) != 8'h00)
			|| (absdiff(brake_pipe, auto_ref) > `AUTO_CHANGE);
		next_auto_ref = (action || state == ST_IDLE) ? brake_pipe : auto_ref;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			level_prev <= '0;
			button_prev <= '0;
			auto_ref <= '0;
		end else begin
			level_prev <= level_now;
			button_prev <= button_now;
			auto_ref <= next_auto_ref;
		end
	end

	// Alertness watchdog
	logic [7:0] elapsed, next_elapsed; // Seconds in COUNT or WARN
	logic [7:0] timeout_now;

	always_comb begin
		// Lead, cut in, and moving, in gear or brakes released
		watch_enable = lead_position && auto_brake_cut_in && (speed > `MOVING_SPEED
			|| reverser_fwd || reverser_rev || brake_cyl < `BC_RELEASED);
		timeout_now = timeout_for(speed);
		next_state = state;
		next_elapsed = sec_tick ? elapsed + 8'h01 : elapsed;
		unique case (state)
			ST_IDLE: begin
				next_elapsed = '0;
				if (watch_enable) next_state = ST_COUNT;
			end
			ST_COUNT: begin
				if (!watch_enable) begin
					next_state = ST_IDLE;
				end else if (action) begin
					next_elapsed = '0;
				end else if (sec_tick && elapsed >= timeout_now - 8'h01) begin
					next_state = ST_WARN;
					next_elapsed = '0;
				end
			end
			ST_WARN: begin
				if (!watch_enable) begin
					next_state = ST_IDLE;
				end else if (action) begin
					next_state = ST_COUNT;
					next_elapsed = '0;
				end else if (sec_tick && elapsed == `AUDIBLE_S - 8'h01) begin
					next_state = ST_PENALTY;
				end
			end
			ST_PENALTY: begin
				// Held until the brake handle reaches suppression
				next_elapsed = '0;
				if (suppression_position) next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
			elapsed <= '0;
		end else begin
			state <= next_state;
			elapsed <= next_elapsed;
		end
	end

	// Valves, alarms and indicators
	logic next_alert_valve, next_overspeed_valve, next_audible, next_visual;

	always_comb begin
		selected_limit = stop_select ? limit_in : limit_out;
		// Trip latches until under speed with the handle in suppression
		next_overspeed_trip = overspeed_trip;
		if (speed > selected_limit) next_overspeed_trip = 1'b1;
		else if (suppression_position) next_overspeed_trip = 1'b0;
		// Energised means healthy, so power loss brakes the train
		next_overspeed_valve = !next_overspeed_trip;
		next_alert_valve = (next_state != ST_PENALTY);
		next_audible = (next_state == ST_WARN);
		next_visual = (next_state == ST_WARN) && (next_elapsed < `VISUAL_S) && flash_on;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			overspeed_trip <= 1'b0;
			overspeed_valve <= 1'b0; // De-energised until running
			alert_valve <= 1'b0;
			alert_audible <= 1'b0;
			alert_visual <= 1'b0;
			horn_valve <= 1'b0;
			aux_lights <= 1'b0;
			zero_speed <= 1'b0;
			stop_system_switched_in <= 1'b0;
			stop_system_switched_out <= 1'b0;
		end else begin
			overspeed_trip <= next_overspeed_trip;
			overspeed_valve <= next_overspeed_valve;
			alert_valve <= next_alert_valve;
			alert_audible <= next_audible;
			alert_visual <= next_visual;
			horn_valve <= horn_sequencer_request;
			aux_lights <= manual_light_request || horn_signal;
			zero_speed <= speed < zero_thr;
			stop_system_switched_in <= stop_select;
			stop_system_switched_out <= !stop_select;
		end
	end

	// Record triggers
	logic [7:0] period_sec, next_period_sec; // Free-running four minute count
	logic [DIG_W-1:0] digital_prev;
	logic [`CAUSE_W-1:0] cause;
	logic speed_delta_trig;

	always_comb begin
		next_period_sec = period_sec;
		if (sec_tick) begin
			next_period_sec = (period_sec == `RECORD_PERIOD_S - 8'h01) ? 8'h00
				: period_sec + 8'h01;
		end
		speed_delta_trig = absdiff(speed, record_speed) >= `SPEED_STEP;
		cause = '0;
		cause[`CAUSE_PERIOD] = sec_tick && period_sec == `RECORD_PERIOD_S - 8'h01;
		cause[`CAUSE_SPEED] = speed_delta_trig;
		cause[`CAUSE_PRESSURE] = absdiff(brake_pipe, record_brake_pipe) >= `PRESSURE_STEP
			|| absdiff(brake_cyl, record_brake_cyl) >= `PRESSURE_STEP;
		cause[`CAUSE_DIGITAL] = digital_inputs != digital_prev;
		cause[`CAUSE_TIMEREF] = time_ref_pulse;
		next_rec_count = (cause != '0) ? rec_count + 32'h00000001 : rec_count;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			period_sec <= '0;
			digital_prev <= '0;
			rec_count <= '0;
			record_strobe <= 1'b0;
			record_cause <= '0;
			record_speed <= '0;
			record_brake_pipe <= '0;
			record_brake_cyl <= '0;
			record_digital <= '0;
		end else begin
			period_sec <= next_period_sec;
			digital_prev <= digital_inputs;
			rec_count <= next_rec_count;
			record_strobe <= cause != '0;
			record_cause <= cause;
			// Every channel is sampled together so deltas use the stored record
			if (cause != '0) begin
				record_speed <= speed;
				record_brake_pipe <= brake_pipe;
				record_brake_cyl <= brake_cyl;
				record_digital <= digital_inputs;
			end
		end
	end

	// Checks
	property p_horn;
		@(posedge mclk) disable iff (reset) horn_sequencer_request |=> horn_valve;
	endproperty
	a_horn: assert property (p_horn) else $error("horn valve missed request");

	property p_lights;
		@(posedge mclk) disable iff (reset)
		(manual_light_request || horn_signal) |=> aux_lights;
	endproperty
	a_lights: assert property (p_lights) else $error("aux lights missed");

	property p_overspeed;
		@(posedge mclk) disable iff (reset) (speed > selected_limit) |=> !overspeed_valve;
	endproperty
	a_overspeed: assert property (p_overspeed) else $error("overspeed valve held");

	property p_zero;
		@(posedge mclk) disable iff (reset) (speed < zero_thr) |=> zero_speed;
	endproperty
	a_zero: assert property (p_zero) else $error("zero speed not shown");

	property p_stop_ind;
		@(posedge mclk) disable iff (reset)
		stop_select |=> stop_system_switched_in && !stop_system_switched_out;
	endproperty
	a_stop_ind: assert property (p_stop_ind) else $error("stop indicator wrong");

	property p_enable;
		@(posedge mclk) disable iff (reset)
		(!watch_enable && state != ST_PENALTY) |=> state == ST_IDLE;
	endproperty
	a_enable: assert property (p_enable) else $error("watchdog ran disabled");

	property p_alarm;
		@(posedge mclk) disable iff (reset) (state == ST_WARN) |-> alert_audible;
	endproperty
	a_alarm: assert property (p_alarm) else $error("audible missing in warn");

	property p_penalty;
		@(posedge mclk) disable iff (reset)
		(state == ST_WARN && watch_enable && !action && sec_tick && elapsed == 8'h13)
		|=> state == ST_PENALTY && !alert_valve && !alert_audible;
	endproperty
	a_penalty: assert property (p_penalty) else $error("penalty not applied");

	property p_restart;
		@(posedge mclk) disable iff (reset)
		(state == ST_WARN && watch_enable && action)
		|=> state == ST_COUNT && elapsed == 8'h00 && !alert_audible && !alert_visual;
	endproperty
	a_restart: assert property (p_restart) else $error("action in window lost");

	property p_rec_speed;
		@(posedge mclk) disable iff (reset) speed_delta_trig |=> record_strobe;
	endproperty
	a_rec_speed: assert property (p_rec_speed) else $error("speed record missed");

	property p_rec_digital;
		@(posedge mclk) disable iff (reset)
		(digital_inputs != digital_prev) |=> record_strobe && record_cause[`CAUSE_DIGITAL];
	endproperty
	a_rec_digital: assert property (p_rec_digital) else $error("edge record missed");

	property p_timeref;
		@(posedge mclk) disable iff (reset)
		time_ref_pulse |=> record_strobe && record_cause[`CAUSE_TIMEREF];
	endproperty
	a_timeref: assert property (p_timeref) else $error("time ref not logged");

	property p_period;
		@(posedge mclk) disable iff (reset)
		(sec_tick && period_sec == 8'hef) |=> record_cause[`CAUSE_PERIOD] && period_sec == 8'h00;
	endproperty
	a_period: assert property (p_period) else $error("periodic record missed");
endmodule

// File: logic/cab_supervisor_defs.svh
// Constants for the cab alertness, overspeed and record trigger block.
// Assumes speeds arrive in tenths of a mph and pressures in tenths of a psi.
`ifndef CAB_SUPERVISOR_DEFS_SVH
`define CAB_SUPERVISOR_DEFS_SVH

// Register byte offsets
`define REG_LIMIT_OUT 8'h00
`define REG_LIMIT_IN 8'h04
`define REG_ZERO_THR 8'h08
`define REG_STATUS 8'h0c
`define REG_REC_COUNT 8'h10

// Reset values of the adjustable thresholds (tenths of a mph)
`define LIMIT_OUT_RESET 16'h033e
`define LIMIT_IN_RESET 16'h03a2
`define ZERO_THR_RESET 16'h001e

// Timing: one second in cycles of the system clock
`define CLK_PERIOD_NS 10
`define SECOND_NS 1000000000
`define SEC_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)
`define RECORD_PERIOD_S 8'hf0
`define VISUAL_S 8'h05
`define AUDIBLE_S 8'h14

// Record trigger and watchdog action/enable thresholds (tenths)
`define SPEED_STEP 16'h000a
`define PRESSURE_STEP 16'h0014
`define INDEP_APPLIED 16'h0096
`define AUTO_CHANGE 16'h0032
`define BC_RELEASED 16'h0096
`define MOVING_SPEED 16'h0005

// Speed breakpoints (tenths of a mph) and their timeouts (seconds)
`define BP_2MPH 16'h0014
`define BP_10MPH 16'h0064
`define BP_20MPH 16'h00c8
`define BP_30MPH 16'h012c
`define BP_40MPH 16'h0190
`define BP_50MPH 16'h01f4
`define BP_60MPH 16'h0258
`define TO_LOW 8'hf0
`define TO_2MPH 8'ha2
`define TO_10MPH 8'h87
`define TO_20MPH 8'h69
`define TO_30MPH 8'h5a
`define TO_40MPH 8'h4d
`define TO_50MPH 8'h44
`define TO_60MPH 8'h3c

// Record cause field positions
`define CAUSE_PERIOD 0
`define CAUSE_SPEED 1
`define CAUSE_PRESSURE 2
`define CAUSE_DIGITAL 3
`define CAUSE_TIMEREF 4
`define CAUSE_W 5

`endif

// File: logic/cab_supervisor_pkg.sv
// Types shared by the cab supervisor block.
// Assumes the constants header is included alongside.
package cab_supervisor_pkg;
	// Alertness watchdog states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_COUNT = 4'h2,
		ST_WARN = 4'h4,
		ST_PENALTY = 4'h8
	} alert_state_type;
endpackage

// File: testbench/cab_valve_panel.sv
// Model of the magnet valve panel that the supervisor drives.
// Assumes valve drives are high while the coil is energised.
`timescale 1ns/1ps
module cab_valve_panel (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Valve drives from the block
	input wire logic alert_valve,
	input wire logic overspeed_valve,
	// Brake state seen in the cab
	output logic penalty_applied
);
	// An unpowered coil vents the pipe, so a dead block means brakes on
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			penalty_applied <= 1'b1;
		end else begin
			penalty_applied <= ~alert_valve | ~overspeed_valve;
		end
	end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the cab supervisor with the valve panel model.
// Assumes a short second (20 cycles) so the watchdog runs in a few thousand cycles.
`timescale 1ns/1ps
`include "cab_supervisor_defs.svh"
module tb;
	// Clock, reset and register port
	logic mclk = 0, reset = 1, reg_write = 0, reg_read = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
	// Measurements, tenths
	logic [15:0] speed = 16'h0, brake_pipe = 16'h0, brake_cyl = 16'h01f4, indep_brake = 16'h0;
	// Operator controls, all idle
	logic lead_position = 0, auto_brake_cut_in = 1, suppression_position = 0, stop_select = 0;
	logic reverser_fwd = 0, reverser_rev = 0, headlight = 0, horn_button = 0, bell = 0;
	logic dyn_brake_setup = 0, console_reset = 0, stop_ack = 0, radio_handle = 0, manual_sand = 0;
	logic horn_sequencer_request = 0, horn_signal = 0, manual_light_request = 0, time_ref_pulse = 0;
	logic [3:0] throttle = 4'h0;
	logic [35:0] digital_inputs = 36'h0, record_digital;
	// Outputs of the block and of the panel
	logic alert_valve, overspeed_valve, horn_valve, aux_lights, alert_audible, alert_visual;
	logic zero_speed, stop_system_switched_in, stop_system_switched_out, record_strobe;
	logic penalty_applied;
	logic [4:0] record_cause;
	logic [15:0] record_speed, record_brake_pipe, record_brake_cyl;
	int err_total = 0, cmp_count = 0, n, vis_last, vis_cnt;
	// Plain table rows: {horn req, horn sig, light, stop sel}, speed, expected outputs
	typedef struct {logic [3:0] ctl; logic [15:0] spd; logic [5:0] exp;} row_type;
	row_type rows [6] = '{'{4'b0000, 16'h0000, 6'b001011}, '{4'b1000, 16'h001d, 6'b101011},
		'{4'b0101, 16'h001e, 6'b010101}, '{4'b0011, 16'h01f4, 6'b010101},
		'{4'b1110, 16'h033e, 6'b110011}, '{4'b0001, 16'h033f, 6'b000101}};

	always #5 mclk = ~mclk;

	cab_supervisor #(.SEC_CYCLES(20), .DIG_W(36)) i_cab_supervisor (.mclk, .reset, .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata, .speed, .brake_pipe, .brake_cyl,
		.indep_brake, .lead_position, .auto_brake_cut_in, .suppression_position, .throttle,
		.reverser_fwd, .reverser_rev, .headlight, .horn_button, .dyn_brake_setup, .bell,
		.console_reset, .stop_ack, .radio_handle, .manual_sand, .stop_select,
		.horn_sequencer_request, .horn_signal, .manual_light_request, .digital_inputs,
		.time_ref_pulse, .alert_valve, .overspeed_valve, .horn_valve, .aux_lights, .alert_audible,
		.alert_visual, .zero_speed, .stop_system_switched_in, .stop_system_switched_out,
		.record_strobe, .record_cause, .record_speed, .record_brake_pipe, .record_brake_cyl,
		.record_digital);
	cab_valve_panel i_cab_valve_panel (.mclk, .reset, .alert_valve, .overspeed_valve,
		.penalty_applied);

	// Verdict and end of run, reached from the main flow and from every bound
	task end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask

	// Data stand only in the cycle after the read edge
	task reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Drive a new speed and let the registered outputs settle
	task spd(input logic [15:0] s);
		@(posedge mclk);
		speed <= s;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	// Look at the recorder in the cycle its strobe stands
	task step_rec(input logic s, input logic [4:0] c);
		@(posedge mclk);
		#1 check(record_strobe, s);
		if (s) check(record_cause, c);
	endtask

	// One operator action of each kind; buttons are pulsed for one cycle
	task poke(input int i);
		// Start on an edge so a release from the last call is not overwritten
		@(posedge mclk);
		case (i)
			0: throttle <= throttle + 4'h1;
			1: horn_button <= 1'b1;
			2: dyn_brake_setup <= 1'b1;
			3: reverser_fwd <= ~reverser_fwd;
			4: bell <= 1'b1;
			5: indep_brake <= 16'h00c8;
			6: brake_pipe <= brake_pipe + 16'h003c;
			7: console_reset <= 1'b1;
			8: stop_ack <= 1'b1;
			9: radio_handle <= 1'b1;
			10: headlight <= ~headlight;
			default: manual_sand <= 1'b1;
		endcase
		@(posedge mclk);
		{horn_button, dyn_brake_setup, bell, console_reset, stop_ack, radio_handle} <= 6'h0;
		manual_sand <= 1'b0;
		indep_brake <= 16'h0;
	endtask

	// Bounded wait for an alarm; a hang ends the run
	task wait_audible(output int c);
		c = 0;
		while (alert_audible !== 1'b1) begin
			@(posedge mclk);
			#1 c++;
			if (c > 3000) begin
				err_total++;
				end_of_test;
			end
		end
	endtask

	// Cycles from one periodic record to the next
	task wait_period(output int c);
		c = 0;
		do begin
			@(posedge mclk);
			#1 c++;
			if (c > 5000) begin
				err_total++;
				end_of_test;
			end
		end while (!(record_strobe === 1'b1 && record_cause[0] === 1'b1));
	endtask

	initial begin
		#1000000;
		err_total++;
		end_of_test;
	end

	initial begin
		repeat (8) @(posedge mclk);
		#1 check({alert_valve, overspeed_valve}, 2'b00);
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		repeat (3) @(posedge mclk);
		#1 check({alert_valve, overspeed_valve, penalty_applied}, 3'b110);
		reg_rd(`REG_LIMIT_OUT, rd);
		check(rd, {16'h0, `LIMIT_OUT_RESET});
		reg_rd(`REG_LIMIT_IN, rd);
		check(rd, {16'h0, `LIMIT_IN_RESET});
		reg_rd(`REG_ZERO_THR, rd);
		check(rd, {16'h0, `ZERO_THR_RESET});
		reg_rd(8'h20, rd);
		check(rd, 32'h0);
		reg_rd(`REG_STATUS, rd);
		check(rd, 32'h1);
		// Cylinder pressure off zero records once on the first edge after reset
		reg_rd(`REG_REC_COUNT, rd);
		check(rd, 32'h1);
		foreach (rows[i]) begin
			@(posedge mclk);
			{horn_sequencer_request, horn_signal, manual_light_request, stop_select} <= rows[i].ctl;
			speed <= rows[i].spd;
			repeat (2) @(posedge mclk);
			#1 check({horn_valve, aux_lights, zero_speed, stop_system_switched_in,
				stop_system_switched_out, overspeed_valve}, rows[i].exp);
		end
		// Recorder thresholds, just below and at each step
		@(posedge mclk) speed <= 16'h0100;
		step_rec(1'b1, 5'h02);
		@(posedge mclk) speed <= 16'h0109;
		step_rec(1'b0, 5'h00);
		@(posedge mclk) speed <= 16'h010a;
		step_rec(1'b1, 5'h02);
		check(record_speed, 16'h010a);
		@(posedge mclk) brake_pipe <= 16'h0013;
		step_rec(1'b0, 5'h00);
		@(posedge mclk) brake_pipe <= 16'h0014;
		step_rec(1'b1, 5'h04);
		check(record_brake_pipe, 16'h0014);
		@(posedge mclk) brake_cyl <= 16'h01e0;
		step_rec(1'b1, 5'h04);
		check(record_brake_cyl, 16'h01e0);
		@(posedge mclk) digital_inputs <= 36'h800000000;
		step_rec(1'b1, 5'h08);
		check(record_digital[35:32], 4'h8);
		@(posedge mclk) digital_inputs <= 36'h0;
		step_rec(1'b1, 5'h08);
		@(posedge mclk) time_ref_pulse <= 1'b1;
		@(posedge mclk) time_ref_pulse <= 1'b0;
		#1 check({record_strobe, record_cause}, 6'h30);
		wait_period(n);
		wait_period(n);
		check(n, 4800);
		// Watchdog at high speed: each action must restart the count
		@(posedge mclk);
		speed <= 16'h02bc;
		lead_position <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			repeat (700) @(posedge mclk);
			#1 check(alert_audible, 1'b0);
			poke(i);
		end
		poke(4);
		wait_audible(n);
		check(n >= 1175 && n <= 1205, 1'b1);
		repeat (100) @(posedge mclk);
		speed <= 16'h0096;
		poke(7);
		repeat (2) @(posedge mclk);
		#1 check({alert_audible, alert_visual}, 2'b00);
		wait_audible(n);
		check(n >= 2670 && n <= 2705, 1'b1);
		// Warning window left to run out
		n = 0;
		vis_last = 0;
		vis_cnt = 0;
		while (alert_valve === 1'b1 && n < 600) begin
			@(posedge mclk);
			#1 n++;
			if (alert_visual === 1'b1) begin
				vis_last = n;
				vis_cnt++;
			end
		end
		check(n >= 395 && n <= 405, 1'b1);
		check(alert_audible, 1'b0);
		check(vis_last >= 1 && vis_last <= 102, 1'b1);
		// Five seconds of half-second flashes, 10 cycles lit per 20-cycle second
		check(vis_cnt, 50);
		poke(4);
		repeat (3) @(posedge mclk);
		#1 check({alert_valve, penalty_applied}, 2'b01);
		@(posedge mclk) suppression_position <= 1'b1;
		repeat (3) @(posedge mclk);
		#1 check(alert_valve, 1'b1);
		@(posedge mclk);
		suppression_position <= 1'b0;
		lead_position <= 1'b0;
		speed <= 16'h02bc;
		repeat (1500) @(posedge mclk);
		#1 check(alert_audible, 1'b0);
		// Overspeed with lowered limits, strict comparison and latch
		// Slow down first: the lowered limit would otherwise latch a trip at once
		spd(16'h0064);
		reg_wr(`REG_LIMIT_OUT, 32'h64);
		@(posedge mclk) stop_select <= 1'b0;
		spd(16'h0064);
		check(overspeed_valve, 1'b1);
		spd(16'h0065);
		check(overspeed_valve, 1'b0);
		spd(16'h0064);
		check(overspeed_valve, 1'b0);
		@(posedge mclk) suppression_position <= 1'b1;
		spd(16'h0064);
		check(overspeed_valve, 1'b1);
		reg_rd(`REG_LIMIT_OUT, rd);
		check(rd, 32'h64);
		@(posedge mclk) stop_select <= 1'b1;
		spd(16'h0065);
		check(overspeed_valve, 1'b1);
		reg_wr(`REG_LIMIT_IN, 32'h64);
		spd(16'h0065);
		check(overspeed_valve, 1'b0);
		reg_wr(`REG_ZERO_THR, 32'h32);
		spd(16'h0031);
		check(zero_speed, 1'b1);
		spd(16'h0032);
		check(zero_speed, 1'b0);
		end_of_test;
	end
endmodule
